// [cni_core_model.sv]
// Protocol core stand-in: drives the bus pin and the bit sample tick.
// Assumes the bench asks for a dominant bus level through domReq.
`timescale 1ns/1ps
module cni_core_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic domReq,
	output logic canRx,
	output logic bitTick
);
	// The bus idles recessive, so bus-off recovery completes on its own.
	assign canRx = ~domReq;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			bitTick <= 1'h0;
		end else begin
			bitTick <= ~bitTick;
		end
	end
endmodule : cni_core_model

// [cni_hit_counter.sv]
// Small wrapping event counter that pulses when its last count is stepped.
// Assumes step and clear come from logic on the same clock.
`timescale 1ns/1ps
module cni_hit_counter #(
	parameter int W = 4,
	parameter logic [W-1:0] LAST = '1
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic step,
	input wire logic clear,
	output logic hit
);
	logic [W-1:0] count_r;
	logic [W-1:0] count_nxt;

	assign hit = step & ~clear & (count_r == LAST);

	always_comb begin
		count_nxt = count_r;
		if (clear) begin
			count_nxt = '0;
		end else if (hit) begin
			count_nxt = '0;
		end else if (step) begin
			count_nxt = count_r + W'(1);
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			count_r <= '0;
		end else begin
			count_r <= count_nxt;
		end
	end
endmodule : cni_hit_counter

// [cni_irq_chk.sv]
// Port assertions for the CAN node interrupt logic.
// Assumes it is bound to cni_irq_logic; one clock, asynchronous reset.
`timescale 1ns/1ps
module cni_irq_chk
	import cni_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [7:0] condHold,
	input wire logic [7:0] rxFaultCount,
	input wire logic [8:0] txFaultCount,
	input wire logic irqN,
	input wire logic [2:0] pendingSourceCode,
	input wire logic [7:0] faultState,
	input wire logic busOffRecovered
);
	logic wr;
	assign wr = psel && penable && pwrite;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	code_needs_irq_a: assert property (
		pendingSourceCode != CNI_CODE_NONE |-> !irqN)
		else $error("code without irq");
	reset_idle_a: assert property (disable iff (1'h0)
		reset |-> irqN && pendingSourceCode == CNI_CODE_NONE)
		else $error("reset state");
	irq_held_a: assert property (
		!irqN && !wr |=> !irqN)
		else $error("irq dropped without host write");
	clear_blocked_a: assert property (
		!irqN && condHold == 8'hFF && !(wr && paddr == CNI_OFS_IRQ_ENABLE)
		|=> !irqN)
		else $error("held flag cleared");
	rx_warn_a: assert property (
		1'h1 |=> faultState[CNI_FLT_RXWARN] ==
		({1'h0, $past(rxFaultCount)} >= CNI_WARN_LIMIT))
		else $error("rx warn");
	tx_passive_a: assert property (
		1'h1 |=> faultState[CNI_FLT_TXPASS] ==
		($past(txFaultCount) > CNI_PASSIVE_LIMIT))
		else $error("tx passive");
	warn_clear_a: assert property (
		1'h1 |=> faultState[CNI_FLT_WARN] ==
		({1'h0, $past(rxFaultCount)} >= CNI_WARN_LIMIT ||
		$past(txFaultCount) >= CNI_WARN_LIMIT))
		else $error("warn level");
	bus_off_a: assert property (
		$rose(txFaultCount[8]) |=> faultState[CNI_FLT_BUSOFF])
		else $error("bus off");
	recover_a: assert property (
		busOffRecovered |-> !faultState[CNI_FLT_BUSOFF])
		else $error("recovery");
endmodule : cni_irq_chk
bind cni_irq_logic cni_irq_chk u_chk (
	.clk(clk),
	.reset(reset),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.condHold(condHold),
	.rxFaultCount(rxFaultCount),
	.txFaultCount(txFaultCount),
	.irqN(irqN),
	.pendingSourceCode(pendingSourceCode),
	.faultState(faultState),
	.busOffRecovered(busOffRecovered)
);

// [cni_irq_logic.sv]
// Interrupt, fault state and wake-up logic of a CAN node, with an APB slave.
// Assumes the protocol core runs on clk and supplies event pulses, hold
// levels, fault counter values and a bit-time tick; canRx is a raw pin.
//
// What this block does
// - Eight interrupt sources, each with an enable bit and a flag bit.
// - Active-low irq goes low on an enabled flag, stays low until cleared.
// - Clearing a flag does nothing while its setting condition persists.
// - Host may set flags; an enabled set flag raises irq like hardware.
// - With several pending, irq stays low until every one is cleared.
// - Code shows top pending source except message fault: error, wake, tx0-2, rx0-1; lower wins.
// - After clearing the top source the code moves to the next, or none.
// - Only enabled sources take part in the pending code.
// - Transmit buffer empty sets its flag and raises irq if enabled.
// - Receive buffer loaded after end of frame sets its full flag.
// - Any message error sets the message fault flag, irq if enabled.
// - Bus activity in sleep sets the activity flag and leaves sleep.
// - Waking on bus activity enters listen-only mode.
// - Overflow or fault state change sets the fault irq, cause recorded.
// - Overflow on a busy receive buffer sets a sticky overflow flag.
// - Receive or transmit fault counter at 96 sets its warning bit.
// - A fault counter above 127 sets its error-passive bit.
// - Transmit fault counter above 255 enters bus-off.
// - Warning clears once both fault counters are below 96.
// - Bus-off ends after 128 runs of 11 recessive bits.
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
module cni_irq_logic
	import cni_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [2:0] txEmptyEvt,
	input wire logic [1:0] rxFullEvt,
	input wire logic msgFaultEvt,
	input wire logic [1:0] rxOverflowEvt,
	input wire logic [7:0] condHold,
	input wire logic [7:0] rxFaultCount,
	input wire logic [8:0] txFaultCount,
	input wire logic bitTick,
	input wire logic canRx,
	output logic irqN,
	output logic [2:0] pendingSourceCode,
	output logic [2:0] opMode,
	output logic [7:0] faultState,
	output logic busOffRecovered
);
	cni_state_t s_r;
	cni_state_t s_nxt;

	logic setupPhase;
	logic accessPhase;
	logic wrEn;
	logic mapped;
	logic [31:0] readValue;
	logic [7:0] hwSet;
	logic [7:0] flagTarget;
	logic [7:0] swSet;
	logic [7:0] swClr;
	logic [7:0] pending;
	logic [1:0] ovClr;
	logic [8:0] rxWide;
	logic rxWarn;
	logic txWarn;
	logic rxPass;
	logic txPass;
	logic txOver;
	logic [5:0] faultLive;
	logic errEvent;
	logic wakeEvent;
	logic runStep;
	logic runClear;
	logic runHit;
	logic runsHit;

	assign setupPhase = psel & ~penable;
	assign accessPhase = psel & penable;
	assign wrEn = accessPhase & pwrite & mapped;

	// Zero wait states: read data is captured in the setup cycle.
	assign pready = 1'b1;
	assign pslverr = accessPhase & ~mapped;
	assign prdata = s_r.rdata;

	assign irqN = s_r.irqN;
	assign pendingSourceCode = s_r.code;
	assign opMode = s_r.mode;
	assign faultState = {s_r.overflow, s_r.faultPrev};
	assign busOffRecovered = s_r.recovered;

	always_comb begin
		mapped = 1'b0;
		if (paddr == CNI_OFS_IRQ_ENABLE) begin
			mapped = 1'b1;
		end else if (paddr == CNI_OFS_IRQ_FLAG) begin
			mapped = 1'b1;
		end else if (paddr == CNI_OFS_FLAG_MODIFY) begin
			mapped = 1'b1;
		end else if (paddr == CNI_OFS_CTRL_STATE) begin
			mapped = 1'b1;
		end else if (paddr == CNI_OFS_FAULT_STATE) begin
			mapped = 1'b1;
		end else if (paddr == CNI_OFS_FAULT_COUNT) begin
			mapped = 1'b1;
		end
	end

	always_comb begin
		readValue = 32'h0000_0000;
		if (paddr == CNI_OFS_IRQ_ENABLE) begin
			readValue[7:0] = s_r.enable;
		end else if (paddr == CNI_OFS_IRQ_FLAG) begin
			readValue[7:0] = s_r.flag;
		end else if (paddr == CNI_OFS_CTRL_STATE) begin
			readValue[CNI_CTRL_MODE_LSB +: 3] = s_r.mode;
			readValue[CNI_CTRL_CODE_LSB +: 3] = s_r.code;
		end else if (paddr == CNI_OFS_FAULT_STATE) begin
			readValue[7:0] = {s_r.overflow, s_r.faultPrev};
		end else if (paddr == CNI_OFS_FAULT_COUNT) begin
			readValue[7:0] = rxFaultCount;
			readValue[CNI_CNT_TX_LSB +: 9] = txFaultCount;
		end
	end

	// Fault thresholds on the counter values from the protocol core.
	always_comb begin
		rxWide = {1'b0, rxFaultCount};
		rxWarn = rxWide >= CNI_WARN_LIMIT;
		txWarn = txFaultCount >= CNI_WARN_LIMIT;
		rxPass = rxWide > CNI_PASSIVE_LIMIT;
		txPass = txFaultCount > CNI_PASSIVE_LIMIT;
		txOver = txFaultCount > CNI_BUSOFF_LIMIT;
	end

	// The recessive run only counts while bus-off; a dominant bit restarts it.
	assign runStep = s_r.busOff & bitTick & s_r.rxSync2;
	assign runClear = ~s_r.busOff | (bitTick & ~s_r.rxSync2);

	cni_hit_counter #(
		.W(4),
		.LAST(CNI_RUN_LAST)
	) u_run_counter (
		.clk(clk),
		.reset(reset),
		.step(runStep),
		.clear(runClear),
		.hit(runHit)
	);

	cni_hit_counter #(
		.W(7),
		.LAST(CNI_RUNS_LAST)
	) u_runs_counter (
		.clk(clk),
		.reset(reset),
		.step(runHit),
		.clear(~s_r.busOff),
		.hit(runsHit)
	);

	// Wake-up looks at the second and third synchroniser stages only.
	assign wakeEvent = (s_r.mode == CNI_MODE_SLEEP) & s_r.rxSync3 &
		~s_r.rxSync2;

	always_comb begin
		s_nxt = s_r;
		s_nxt.rxSync1 = canRx;
		s_nxt.rxSync2 = s_r.rxSync1;
		s_nxt.rxSync3 = s_r.rxSync2;
		s_nxt.recovered = runsHit;
		if (setupPhase) begin
			s_nxt.rdata = readValue;
		end

		// Bus-off is entered on the crossing so that a counter still above
		// the limit right after recovery does not trap the node again.
		s_nxt.txOverPrev = txOver;
		if (runsHit) begin
			s_nxt.busOff = 1'b0;
		end else if (txOver & ~s_r.txOverPrev) begin
			s_nxt.busOff = 1'b1;
		end

		faultLive[CNI_FLT_WARN] = rxWarn | txWarn;
		faultLive[CNI_FLT_RXWARN] = rxWarn;
		faultLive[CNI_FLT_TXWARN] = txWarn;
		faultLive[CNI_FLT_RXPASS] = rxPass;
		faultLive[CNI_FLT_TXPASS] = txPass;
		faultLive[CNI_FLT_BUSOFF] = s_nxt.busOff;
		s_nxt.faultPrev = faultLive;

		ovClr = 2'b00;
		if (wrEn & (paddr == CNI_OFS_FAULT_STATE)) begin
			ovClr = ~pwdata[CNI_FLT_OVR_LSB +: 2];
		end
		// A new overflow beats a clear in the same cycle.
		s_nxt.overflow = (s_r.overflow & ~ovClr) | rxOverflowEvt;

		errEvent = (|rxOverflowEvt) | (faultLive != s_r.faultPrev);

		hwSet = 8'h00;
		hwSet[CNI_BIT_RX0] = rxFullEvt[0];
		hwSet[CNI_BIT_RX1] = rxFullEvt[1];
		hwSet[CNI_BIT_TX0] = txEmptyEvt[0];
		hwSet[CNI_BIT_TX1] = txEmptyEvt[1];
		hwSet[CNI_BIT_TX2] = txEmptyEvt[2];
		hwSet[CNI_BIT_ERR] = errEvent;
		hwSet[CNI_BIT_WAK] = wakeEvent;
		hwSet[CNI_BIT_MERR] = msgFaultEvt;

		// A plain write replaces all flags; the modify word touches only the
		// masked ones, which is the safe way to clear.
		flagTarget = s_r.flag;
		if (wrEn & (paddr == CNI_OFS_IRQ_FLAG)) begin
			flagTarget = pwdata[7:0];
		end else if (wrEn & (paddr == CNI_OFS_FLAG_MODIFY)) begin
			flagTarget = (s_r.flag & ~pwdata[CNI_MOD_MASK_LSB +: 8]) |
				(pwdata[7:0] & pwdata[CNI_MOD_MASK_LSB +: 8]);
		end
		swSet = flagTarget & ~s_r.flag;
		swClr = ~flagTarget & s_r.flag & ~condHold;
		s_nxt.flag = (s_r.flag & ~swClr) | swSet | hwSet;

		if (wrEn & (paddr == CNI_OFS_IRQ_ENABLE)) begin
			s_nxt.enable = pwdata[7:0];
		end

		if (wakeEvent) begin
			s_nxt.mode = CNI_MODE_LISTEN;
		end else if (wrEn & (paddr == CNI_OFS_CTRL_STATE)) begin
			s_nxt.mode = pwdata[CNI_CTRL_MODE_LSB +: 3];
		end

		pending = s_nxt.flag & s_nxt.enable;
		s_nxt.irqN = ~(|pending);

		if (pending[CNI_BIT_ERR]) begin
			s_nxt.code = CNI_CODE_ERR;
		end else if (pending[CNI_BIT_WAK]) begin
			s_nxt.code = CNI_CODE_WAK;
		end else if (pending[CNI_BIT_TX0]) begin
			s_nxt.code = CNI_CODE_TX0;
		end else if (pending[CNI_BIT_TX1]) begin
			s_nxt.code = CNI_CODE_TX1;
		end else if (pending[CNI_BIT_TX2]) begin
			s_nxt.code = CNI_CODE_TX2;
		end else if (pending[CNI_BIT_RX0]) begin
			s_nxt.code = CNI_CODE_RX0;
		end else if (pending[CNI_BIT_RX1]) begin
			s_nxt.code = CNI_CODE_RX1;
		end else begin
			s_nxt.code = CNI_CODE_NONE;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_r.enable <= CNI_RST_ENABLE;
			s_r.flag <= CNI_RST_FLAG;
			s_r.mode <= CNI_RST_MODE;
			s_r.code <= CNI_CODE_NONE;
			s_r.irqN <= 1'b1;
			s_r.overflow <= 2'b00;
			s_r.busOff <= 1'b0;
			s_r.txOverPrev <= 1'b0;
			s_r.faultPrev <= 6'h00;
			s_r.recovered <= 1'b0;
			s_r.rxSync1 <= 1'b1;
			s_r.rxSync2 <= 1'b1;
			s_r.rxSync3 <= 1'b1;
			s_r.rdata <= 32'h0000_0000;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule : cni_irq_logic

// [cni_irq_logic_bench.sv]
// Self-checking bench for the CAN node interrupt logic.
// Assumes the core model drives canRx and bitTick; the bench is APB master.
`timescale 1ns/1ps
module cni_irq_logic_bench;
	import cni_pkg::*;
	logic clk, reset, psel, penable, pwrite, pready, pslverr, irqN, slvErr;
	logic msgFaultEvt, bitTick, canRx, busOffRecovered, domReq;
	logic [7:0] paddr, condHold, rxFaultCount, faultState;
	logic [31:0] pwdata, prdata, q;
	logic [2:0] txEmptyEvt, pendingSourceCode, opMode;
	logic [1:0] rxFullEvt, rxOverflowEvt;
	logic [8:0] txFaultCount;
	int fail_count = 0;
	int samples_checked = 0;
	// Enable, flag, expected code, expected irqN.
	logic [23:0] rows [11] = '{24'hFF01_60, 24'hFF02_70, 24'hFF04_30,
		24'hFF08_40, 24'hFF10_50, 24'hFF20_10, 24'hFF40_20, 24'hFF80_00,
		24'h7FFF_10, 24'h00FF_01, 24'h181C_40};
	cni_irq_logic uut (.*);
	cni_core_model core (.*);
	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		final_report;
	end
	task automatic final_report;
		$display("checks %0d failures %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : final_report
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		samples_checked++;
		if (s !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
			fail_count++;
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		// Ends when pready is seen high, with no limit but the watchdog; the slave decides the latency.
		do begin
			@(posedge clk);
		end while (pready !== 1'h1);
		q = prdata;
		slvErr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic ev(input logic [7:0] v);
		@(posedge clk);
		{rxOverflowEvt, msgFaultEvt, rxFullEvt, txEmptyEvt} <= v;
		@(posedge clk);
		{rxOverflowEvt, msgFaultEvt, rxFullEvt, txEmptyEvt} <= 8'h00;
		#1;
	endtask : ev
	task automatic clr(input logic [7:0] m);
		apb(1'h1, CNI_OFS_FLAG_MODIFY, {16'h0000, m, 8'h00});
		#1;
	endtask : clr
	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask : settle
	initial begin
		{psel, penable, pwrite, domReq, msgFaultEvt} = 5'h00;
		{txEmptyEvt, rxFullEvt, rxOverflowEvt} = 7'h00;
		{paddr, condHold, rxFaultCount, txFaultCount} = 33'h0;
		pwdata = 32'h0;
		reset = 1'h1;
		repeat (8) @(posedge clk);
		reset <= 1'h0;
		apb(1'h0, CNI_OFS_IRQ_ENABLE, 32'h0);
		chk("enable", CNI_RST_ENABLE, q);
		chk("irqN", 1'h1, irqN);
		chk("mode", CNI_RST_MODE, opMode);
		$display("reset test done");
		foreach (rows[i]) begin
			apb(1'h1, CNI_OFS_IRQ_ENABLE, 32'(rows[i][23:16]));
			apb(1'h1, CNI_OFS_IRQ_FLAG, 32'(rows[i][15:8]));
			#1;
			chk("code", rows[i][6:4], pendingSourceCode);
			chk("irqN", rows[i][0], irqN);
			apb(1'h0, CNI_OFS_CTRL_STATE, 32'h0);
			chk("code field", rows[i][6:4], q[3:1]);
			apb(1'h1, CNI_OFS_IRQ_FLAG, 32'h0);
		end
		$display("table done");
		apb(1'h1, CNI_OFS_IRQ_ENABLE, 32'h0000_00FF);
		ev(8'h0A);
		chk("tx1 code", CNI_CODE_TX1, pendingSourceCode);
		clr(8'h08);
		chk("next code", CNI_CODE_RX0, pendingSourceCode);
		chk("irq held", 1'h0, irqN);
		clr(8'h01);
		chk("irq off", 1'h1, irqN);
		ev(8'h20);
		chk("merr irq", 1'h0, irqN);
		clr(8'h80);
		@(posedge clk);
		condHold <= 8'hFF;
		ev(8'h10);
		clr(8'h02);
		chk("held", CNI_CODE_RX1, pendingSourceCode);
		apb(1'h0, CNI_OFS_IRQ_FLAG, 32'h0);
		chk("flag held", 32'h0000_0002, q);
		@(posedge clk);
		condHold <= 8'h00;
		clr(8'h02);
		chk("released", 1'h1, irqN);
		$display("event test done");
		@(posedge clk);
		rxFaultCount <= 8'h60;
		settle;
		chk("rx warn", 8'h03, faultState);
		chk("err code", CNI_CODE_ERR, pendingSourceCode);
		@(posedge clk);
		txFaultCount <= 9'h080;
		settle;
		chk("tx passive", 8'h17, faultState);
		@(posedge clk);
		txFaultCount <= 9'h100;
		settle;
		chk("bus off", 8'h37, faultState);
		apb(1'h0, CNI_OFS_FAULT_STATE, 32'h0);
		chk("state reg", 32'h0000_0037, q);
		apb(1'h0, CNI_OFS_FAULT_COUNT, 32'h0);
		chk("counts", 32'h0001_0060, q);
		for (int n = 0; n < 4000 && busOffRecovered !== 1'h1; n++) begin
			@(posedge clk);
			#1;
		end
		chk("recovery", 1'h1, busOffRecovered);
		#1;
		chk("active", 1'h0, faultState[CNI_FLT_BUSOFF]);
		@(posedge clk);
		{rxFaultCount, txFaultCount} <= 17'h0;
		settle;
		chk("warn clear", 8'h00, faultState);
		clr(8'h20);
		ev(8'h80);
		chk("overflow", 1'h1, faultState[7]);
		chk("ovr code", CNI_CODE_ERR, pendingSourceCode);
		clr(8'h20);
		chk("sticky", 1'h1, faultState[7]);
		apb(1'h0, CNI_OFS_FAULT_STATE, 32'h0);
		chk("ovr reg", 32'h0000_0080, q);
		apb(1'h1, CNI_OFS_FAULT_STATE, 32'h0);
		#1;
		chk("ovr clear", 1'h0, faultState[7]);
		$display("fault test done");
		apb(1'h1, CNI_OFS_CTRL_STATE, 32'h0000_0020);
		#1;
		chk("sleep", CNI_MODE_SLEEP, opMode);
		@(posedge clk);
		domReq <= 1'h1;
		for (int n = 0; n < 20 && opMode !== CNI_MODE_LISTEN; n++) begin
			@(posedge clk);
			#1;
		end
		chk("listen", CNI_MODE_LISTEN, opMode);
		chk("wake code", CNI_CODE_WAK, pendingSourceCode);
		@(posedge clk);
		domReq <= 1'h0;
		clr(8'h40);
		apb(1'h0, 8'h20, 32'h0);
		chk("slverr", 1'h1, slvErr);
		chk("unmapped", 32'h0, q);
		$display("wake and bus test done");
		ev(8'h01);
		chk("tx0 irq", 1'h0, irqN);
		@(posedge clk);
		reset <= 1'h1;
		#1;
		chk("reset irqN", 1'h1, irqN);
		chk("reset code", CNI_CODE_NONE, pendingSourceCode);
		chk("reset mode", CNI_RST_MODE, opMode);
		chk("reset fault", 8'h00, faultState);
		@(posedge clk);
		reset <= 1'h0;
		apb(1'h0, CNI_OFS_IRQ_FLAG, 32'h0);
		chk("reset flags", CNI_RST_FLAG, q);
		chk("idle irqN", 1'h1, irqN);
		$display("mid-run reset test done");
		final_report;
	end
endmodule : cni_irq_logic_bench

// [cni_pkg.sv]
// Constants, register map and state layout of the CAN node interrupt logic.
// Assumes an APB master with 32-bit data and byte addresses on paddr.
package cni_pkg;

	// Register byte offsets on the APB side.
	localparam logic [7:0] CNI_OFS_IRQ_ENABLE = 8'h00;
	localparam logic [7:0] CNI_OFS_IRQ_FLAG = 8'h04;
	localparam logic [7:0] CNI_OFS_FLAG_MODIFY = 8'h08;
	localparam logic [7:0] CNI_OFS_CTRL_STATE = 8'h0C;
	localparam logic [7:0] CNI_OFS_FAULT_STATE = 8'h10;
	localparam logic [7:0] CNI_OFS_FAULT_COUNT = 8'h14;

	// Bit positions shared by the enable and flag registers.
	localparam int CNI_BIT_RX0 = 0;
	localparam int CNI_BIT_RX1 = 1;
	localparam int CNI_BIT_TX0 = 2;
	localparam int CNI_BIT_TX1 = 3;
	localparam int CNI_BIT_TX2 = 4;
	localparam int CNI_BIT_ERR = 5;
	localparam int CNI_BIT_WAK = 6;
	localparam int CNI_BIT_MERR = 7;

	// Bit positions of the fault state register.
	localparam int CNI_FLT_WARN = 0;
	localparam int CNI_FLT_RXWARN = 1;
	localparam int CNI_FLT_TXWARN = 2;
	localparam int CNI_FLT_RXPASS = 3;
	localparam int CNI_FLT_TXPASS = 4;
	localparam int CNI_FLT_BUSOFF = 5;
	localparam int CNI_FLT_OVR_LSB = 6;

	// Field positions of the controller state register, modify word and fault count register.
	localparam int CNI_CTRL_MODE_LSB = 5;
	localparam int CNI_CTRL_CODE_LSB = 1;
	localparam int CNI_MOD_MASK_LSB = 8;
	localparam int CNI_CNT_TX_LSB = 8;

	// Operating modes.
	localparam logic [2:0] CNI_MODE_NORMAL = 3'h0;
	localparam logic [2:0] CNI_MODE_SLEEP = 3'h1;
	localparam logic [2:0] CNI_MODE_LOOPBACK = 3'h2;
	localparam logic [2:0] CNI_MODE_LISTEN = 3'h3;
	localparam logic [2:0] CNI_MODE_CONFIG = 3'h4;

	// Pending source codes, lower value wins.
	localparam logic [2:0] CNI_CODE_NONE = 3'h0;
	localparam logic [2:0] CNI_CODE_ERR = 3'h1;
	localparam logic [2:0] CNI_CODE_WAK = 3'h2;
	localparam logic [2:0] CNI_CODE_TX0 = 3'h3;
	localparam logic [2:0] CNI_CODE_TX1 = 3'h4;
	localparam logic [2:0] CNI_CODE_TX2 = 3'h5;
	localparam logic [2:0] CNI_CODE_RX0 = 3'h6;
	localparam logic [2:0] CNI_CODE_RX1 = 3'h7;

	// Fault counter thresholds, at the width of the transmit counter.
	localparam logic [8:0] CNI_WARN_LIMIT = 9'h060;
	localparam logic [8:0] CNI_PASSIVE_LIMIT = 9'h07F;
	localparam logic [8:0] CNI_BUSOFF_LIMIT = 9'h0FF;

	// Bus-off recovery: last count of the recessive run and of the runs.
	localparam logic [3:0] CNI_RUN_LAST = 4'hA;
	localparam logic [6:0] CNI_RUNS_LAST = 7'h7F;

	// Values after reset.
	localparam logic [7:0] CNI_RST_ENABLE = 8'h00;
	localparam logic [7:0] CNI_RST_FLAG = 8'h00;
	localparam logic [2:0] CNI_RST_MODE = CNI_MODE_CONFIG;

	typedef struct packed {
		logic [7:0] enable;
		logic [7:0] flag;
		logic [2:0] mode;
		logic [2:0] code;
		logic irqN;
		logic [1:0] overflow;
		logic busOff;
		logic txOverPrev;
		logic [5:0] faultPrev;
		logic recovered;
		logic rxSync1;
		logic rxSync2;
		logic rxSync3;
		logic [31:0] rdata;
	} cni_state_t;

endpackage : cni_pkg
